/* pkg/pixel_expand_pkg.sv */
`default_nettype none
package pixel_expand_pkg;
	// Register byte offsets
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_DIMS = 5'h04;
	localparam logic [4:0] OFS_GEOM = 5'h08;
	localparam logic [4:0] OFS_STAT = 5'h0C;
	localparam logic [4:0] OFS_TOTAL = 5'h10;
	localparam logic [4:0] OFS_SETUP = 5'h14;
	// Control fields
	localparam int CTRL_START = 0;
	localparam int CTRL_RESUME = 1;
	localparam int CTRL_XY = 2;
	localparam int CTRL_WIN_LSB = 3;
	localparam int CTRL_DIRH = 6;
	localparam int CTRL_DIRV = 7;
	localparam int CTRL_OP_LSB = 8;
	localparam int CTRL_MASK = 10;
	// Dimension fields
	localparam int DIMS_DX_LSB = 0;
	localparam int DIMS_DY_LSB = 16;
	// Geometry fields
	localparam int GEOM_N_LSB = 0;
	localparam int GEOM_Y_LSB = 8;
	localparam int GEOM_R_LSB = 16;
	localparam int GEOM_V_LSB = 18;
	localparam int GEOM_ALIGN_LSB = 20;
	localparam int GEOM_PIXEL_WIDTH_REGISTER_LSB = 24;
	// Status fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_INTR = 2;
	localparam int STAT_SUSP = 3;
	localparam int STAT_CASE_LSB = 4;
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] DIMS_RST = 32'h0000_0000;
	localparam logic [31:0] GEOM_RST = 32'h0000_0000;
	// Setup costs in machine states
	localparam logic [15:0] SETUP_LINEAR = 16'h0004;
	localparam logic [15:0] SETUP_XY_OFF = 16'h0006;
	localparam logic [15:0] SETUP_FITS = 16'h0009;
	localparam logic [15:0] SETUP_START = 16'h0011;
	localparam logic [15:0] SETUP_DIM = 16'h000C;
	localparam logic [15:0] SETUP_BOTH = 16'h0015;
	// Per-word graphics costs
	localparam logic [15:0] G_REPLACE = 16'h0002;
	localparam logic [15:0] G_BOOL = 16'h0004;
	localparam logic [15:0] G_ARITH = 16'h0005;
	localparam logic [15:0] G_SUBS = 16'h0006;
	localparam logic [15:0] RMW_EXTRA = 16'h0002;
	// Transfer costs
	localparam logic [15:0] BASE_NARROW = 16'h0003;
	localparam logic [15:0] BASE_WIDE = 16'h0005;
	localparam logic [15:0] LONG_SET_AB = 16'h0003;
	localparam logic [15:0] LONG_SET_CD = 16'h0008;
	localparam logic [15:0] LONG_TAIL_CD = 16'h0008;
	localparam logic [15:0] FINAL_STATES = 16'h0003;
	localparam logic [15:0] ADJ_BC = 16'h0002;
	localparam logic [15:0] ADJ_D = 16'h0004;
	localparam logic [15:0] SRC_SHORT_BITS = 16'h0010;
	localparam logic [15:0] SET_BITS = 16'h0020;
	localparam int RECOG_STATES = 20;
	typedef enum logic [2:0] {WIN_OFF, WIN_FITS, WIN_START, WIN_DIM, WIN_BOTH} win_t;
	typedef enum logic [1:0] {OP_REPLACE, OP_BOOL, OP_ARITH, OP_SUBS} op_t;
	typedef enum logic [1:0] {AL_A, AL_B, AL_C, AL_D} align_t;
	typedef enum logic [1:0] {CASE_SHORT, CASE_MEDIUM, CASE_LONG} row_case_t;
	typedef struct packed {
		logic xy;
		logic [2:0] win;
		logic [1:0] op;
		logic mask;
		logic [15:0] dy;
		logic [15:0] dx;
		logic [7:0] n;
		logic [7:0] y;
		logic [1:0] r;
		logic [1:0] v;
		logic [1:0] align;
		logic [4:0] pixel_width_register;
	} cfg_t;
endpackage
`default_nettype wire

/* src/pixel_block_expand_timing.sv */
// Function
// - Total equals setup plus transfer less alignment adjustment.
// - Setup does init, XY conversion, preclip, yields source dimensions.
// - Setup is 4 states linear, 6 states XY without window.
// - XY window setup: fits 9, start 17, both corners 21.
// - XY setup with end corner adjust only takes 12 states.
// - Direction bits add nothing to setup.
// - Short row costs (3+2R+G)L+3, alignment ignored.
// - Medium rows cost (3+2R+NG) for A/C, (5+2R+NG) for B/D.
// - Long rows cost per-set heads plus tail, by alignment pair.
// - Long rows run 32-pixel sets serially, then a final partial segment.
// - Set count is width/32, minus one when even.
// - Each set reads two or three source words.
// - Leftover bits take one to three reads, then remaining words.
// - Rows split into leading, N-2 center, trailing words.
// - Center words whole; trailing word sets alignment type.
// - Transfer always advances increasing X then Y; direction bits ignored.
// - Plain word cost: replace 2, Boolean/ADD 4, ADDS/SUB/MAX/MIN 5, SUBS 6.
// - Masked or RMW word cost: 4, 6, 7, 8.
// - Masking, transparency, field insertion add fixed 2 per word.
// - Masking subtracts 2 per row for B/C, 4 for D.
// - Row count is the clipped destination row count.
// - Interrupt taken at word boundary or row end within 20 states.
`timescale 1ns/1ps
`default_nettype none
module pixel_block_expand_timing (
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic [4:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic INT_REQ,
	output logic INT_TAKEN,
	output logic BUSY,
	output logic INTERRUPTED
);
	typedef enum logic [2:0] {S_IDLE, S_SETUP, S_HEAD, S_WORD, S_ROWEND, S_SUSP, S_FINAL} seq_t;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				m[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return m;
	endfunction

	function automatic logic [15:0] g_cost(input logic [1:0] op, input logic rmw);
		logic [15:0] g;
		g = pixel_expand_pkg::G_REPLACE;
		unique case (pixel_expand_pkg::op_t'(op))
			pixel_expand_pkg::OP_REPLACE: g = pixel_expand_pkg::G_REPLACE;
			pixel_expand_pkg::OP_BOOL: g = pixel_expand_pkg::G_BOOL;
			pixel_expand_pkg::OP_ARITH: g = pixel_expand_pkg::G_ARITH;
			pixel_expand_pkg::OP_SUBS: g = pixel_expand_pkg::G_SUBS;
		endcase
		return rmw ? g + pixel_expand_pkg::RMW_EXTRA : g;
	endfunction

	function automatic logic [15:0] setup_cost(input logic xy, input logic [2:0] win);
		logic [15:0] c;
		c = pixel_expand_pkg::SETUP_XY_OFF;
		unique case (pixel_expand_pkg::win_t'(win))
			pixel_expand_pkg::WIN_OFF: c = pixel_expand_pkg::SETUP_XY_OFF;
			pixel_expand_pkg::WIN_FITS: c = pixel_expand_pkg::SETUP_FITS;
			pixel_expand_pkg::WIN_START: c = pixel_expand_pkg::SETUP_START;
			pixel_expand_pkg::WIN_DIM: c = pixel_expand_pkg::SETUP_DIM;
			pixel_expand_pkg::WIN_BOTH: c = pixel_expand_pkg::SETUP_BOTH;
			default: c = pixel_expand_pkg::SETUP_XY_OFF;
		endcase
		return xy ? c : pixel_expand_pkg::SETUP_LINEAR;
	endfunction

	function automatic logic [15:0] set_count(input logic [15:0] dx);
		logic [10:0] s;
		s = dx[15:5];
		if (s != 11'h000 && !s[0]) begin
			s = s - 11'h001;
		end
		return {5'h00, s};
	endfunction

	function automatic pixel_expand_pkg::cfg_t pack_cfg(input logic [31:0] c,
			input logic [31:0] d, input logic [31:0] g);
		pixel_expand_pkg::cfg_t f;
		f.xy = c[pixel_expand_pkg::CTRL_XY];
		f.win = c[pixel_expand_pkg::CTRL_WIN_LSB +: 3];
		f.op = c[pixel_expand_pkg::CTRL_OP_LSB +: 2];
		f.mask = c[pixel_expand_pkg::CTRL_MASK];
		f.dy = d[pixel_expand_pkg::DIMS_DY_LSB +: 16];
		f.dx = d[pixel_expand_pkg::DIMS_DX_LSB +: 16];
		f.n = g[pixel_expand_pkg::GEOM_N_LSB +: 8];
		f.y = g[pixel_expand_pkg::GEOM_Y_LSB +: 8];
		f.r = g[pixel_expand_pkg::GEOM_R_LSB +: 2];
		f.v = g[pixel_expand_pkg::GEOM_V_LSB +: 2];
		f.align = g[pixel_expand_pkg::GEOM_ALIGN_LSB +: 2];
		f.pixel_width_register = g[pixel_expand_pkg::GEOM_PIXEL_WIDTH_REGISTER_LSB +: 5];
		return f;
	endfunction

	logic [31:0] ctrl_r, dims_r, geom_r, rdata_r, total_r;
	logic [15:0] setup_len_r, cnt_r, cnt_nxt, row_r, row_nxt, set_r, set_nxt;
	logic [15:0] word_r, word_nxt, ret_cnt_r;
	logic [15:0] g, set_head, tail_head, tail_words, set_words, adj, sets, two_r, two_v;
	logic waitreq_r, start_r, resume_r, done_r, intr_r, taken_r, busy_r;
	logic seg_set_r, seg_nxt, take, last, counted, boundary, bd_wide, bd_cd;
	logic int_s1, int_s2, int_s3, int_lvl_r, int_pend_r;
	seq_t state_r, state_nxt, ret_r, ret_nxt;
	pixel_expand_pkg::cfg_t run_r;
	pixel_expand_pkg::row_case_t rcase;

	assign AVS_READDATA = rdata_r;
	assign AVS_WAITREQUEST = waitreq_r;
	assign INT_TAKEN = taken_r;
	assign BUSY = busy_r;
	assign INTERRUPTED = intr_r;

	// Avalon slave: one wait state, then a single answer cycle
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			waitreq_r <= 1'b1;
		end else begin
			waitreq_r <= !((AVS_READ || AVS_WRITE) && waitreq_r);
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rdata_r <= 32'h0000_0000;
		end else if (AVS_READ && waitreq_r) begin
			unique case (AVS_ADDRESS)
				pixel_expand_pkg::OFS_CTRL: rdata_r <= ctrl_r;
				pixel_expand_pkg::OFS_DIMS: rdata_r <= dims_r;
				pixel_expand_pkg::OFS_GEOM: rdata_r <= geom_r;
				pixel_expand_pkg::OFS_STAT: rdata_r <= {26'h000_0000, rcase,
					state_r == S_SUSP, intr_r, done_r, busy_r};
				pixel_expand_pkg::OFS_TOTAL: rdata_r <= total_r;
				pixel_expand_pkg::OFS_SETUP: rdata_r <= {16'h0000, setup_len_r};
				default: rdata_r <= 32'h0000_0000;
			endcase
		end
	end

	// Register writes take effect at the answer edge
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			ctrl_r <= pixel_expand_pkg::CTRL_RST;
			dims_r <= pixel_expand_pkg::DIMS_RST;
			geom_r <= pixel_expand_pkg::GEOM_RST;
			start_r <= 1'b0;
			resume_r <= 1'b0;
		end else begin
			start_r <= 1'b0;
			resume_r <= 1'b0;
			if (AVS_WRITE && !waitreq_r) begin
				unique case (AVS_ADDRESS)
					pixel_expand_pkg::OFS_CTRL: begin
						ctrl_r <= merge(ctrl_r, AVS_WRITEDATA, AVS_BYTEENABLE) & 32'hFFFF_FFFC;
						start_r <= AVS_BYTEENABLE[0] && AVS_WRITEDATA[pixel_expand_pkg::CTRL_START];
						resume_r <= AVS_BYTEENABLE[0] && AVS_WRITEDATA[pixel_expand_pkg::CTRL_RESUME];
					end
					pixel_expand_pkg::OFS_DIMS: dims_r <= merge(dims_r, AVS_WRITEDATA, AVS_BYTEENABLE);
					pixel_expand_pkg::OFS_GEOM: geom_r <= merge(geom_r, AVS_WRITEDATA, AVS_BYTEENABLE);
					default: ;
				endcase
			end
		end
	end

	// Interrupt pin: three stages, level moves when stages two and three agree
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			int_s1 <= 1'b0;
			int_s2 <= 1'b0;
			int_s3 <= 1'b0;
			int_lvl_r <= 1'b0;
			int_pend_r <= 1'b0;
		end else begin
			int_s1 <= INT_REQ;
			int_s2 <= int_s1;
			int_s3 <= int_s2;
			if (int_s2 == int_s3) begin
				int_lvl_r <= int_s3;
			end
			int_pend_r <= (int_s2 == int_s3 && int_s3 && !int_lvl_r) || (int_pend_r && !take);
		end
	end

	// Per-row and per-set costs of the running operation
	always_comb begin
		two_r = {13'h0000, run_r.r, 1'b0};
		two_v = {13'h0000, run_r.v, 1'b0};
		g = g_cost(run_r.op, run_r.mask);
		sets = set_count(run_r.dx);
		bd_wide = run_r.align == pixel_expand_pkg::AL_B || run_r.align == pixel_expand_pkg::AL_D;
		bd_cd = run_r.align == pixel_expand_pkg::AL_C || run_r.align == pixel_expand_pkg::AL_D;
		if (run_r.dx > pixel_expand_pkg::SET_BITS) begin
			rcase = pixel_expand_pkg::CASE_LONG;
		end else if (run_r.n <= 8'h01 && run_r.dx <= pixel_expand_pkg::SRC_SHORT_BITS) begin
			rcase = pixel_expand_pkg::CASE_SHORT;
		end else begin
			rcase = pixel_expand_pkg::CASE_MEDIUM;
		end
		set_head = (bd_cd ? pixel_expand_pkg::LONG_SET_CD : pixel_expand_pkg::LONG_SET_AB)
			+ two_r;
		set_words = {10'h000, run_r.pixel_width_register, 1'b0};
		unique case (rcase)
			pixel_expand_pkg::CASE_SHORT: begin
				tail_head = pixel_expand_pkg::BASE_NARROW + two_r;
				tail_words = 16'h0001;
			end
			pixel_expand_pkg::CASE_MEDIUM: begin
				tail_head = (bd_wide ? pixel_expand_pkg::BASE_WIDE : pixel_expand_pkg::BASE_NARROW)
					+ two_r;
				tail_words = {8'h00, run_r.n};
			end
			default: begin
				tail_head = two_v + (bd_cd ? pixel_expand_pkg::LONG_TAIL_CD : 16'h0000);
				tail_words = {8'h00, bd_cd ? run_r.y : run_r.n};
			end
		endcase
		adj = 16'h0000;
		if (run_r.mask) begin
			unique case (pixel_expand_pkg::align_t'(run_r.align))
				pixel_expand_pkg::AL_A: adj = 16'h0000;
				pixel_expand_pkg::AL_B: adj = pixel_expand_pkg::ADJ_BC;
				pixel_expand_pkg::AL_C: adj = pixel_expand_pkg::ADJ_BC;
				pixel_expand_pkg::AL_D: adj = pixel_expand_pkg::ADJ_D;
			endcase
		end
	end

	// Sequencer next state; direction bits are never consulted
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		row_nxt = row_r;
		set_nxt = set_r;
		word_nxt = word_r;
		seg_nxt = seg_set_r;
		ret_nxt = ret_r;
		last = cnt_r <= 16'h0001;
		boundary = 1'b0;
		unique case (state_r)
			S_IDLE: if (start_r) begin
				state_nxt = S_SETUP;
				cnt_nxt = setup_cost(ctrl_r[pixel_expand_pkg::CTRL_XY],
					ctrl_r[pixel_expand_pkg::CTRL_WIN_LSB +: 3]);
			end
			S_SETUP: if (last) begin
				row_nxt = run_r.dy;
				state_nxt = run_r.dy == 16'h0000 ? S_FINAL : S_HEAD;
				seg_nxt = rcase == pixel_expand_pkg::CASE_LONG && sets != 16'h0000;
				set_nxt = sets;
				cnt_nxt = run_r.dy == 16'h0000 ? pixel_expand_pkg::FINAL_STATES
					: (seg_nxt ? set_head : tail_head);
			end
			S_HEAD: if (last) begin
				boundary = 1'b1;
				state_nxt = S_WORD;
				word_nxt = seg_set_r ? set_words : tail_words;
				cnt_nxt = g;
			end
			S_WORD: if (last || word_r == 16'h0000) begin
				boundary = 1'b1;
				cnt_nxt = g;
				if (word_r > 16'h0001) begin
					word_nxt = word_r - 16'h0001;
				end else if (seg_set_r && set_r > 16'h0001) begin
					set_nxt = set_r - 16'h0001;
					state_nxt = S_HEAD;
					cnt_nxt = set_head;
				end else if (seg_set_r) begin
					seg_nxt = 1'b0;
					state_nxt = S_HEAD;
					cnt_nxt = tail_head;
				end else begin
					state_nxt = S_ROWEND;
				end
			end
			S_ROWEND: begin
				boundary = 1'b1;
				row_nxt = row_r - 16'h0001;
				state_nxt = row_r <= 16'h0001 ? S_FINAL : S_HEAD;
				seg_nxt = rcase == pixel_expand_pkg::CASE_LONG && sets != 16'h0000;
				set_nxt = sets;
				cnt_nxt = row_r <= 16'h0001 ? pixel_expand_pkg::FINAL_STATES
					: (seg_nxt ? set_head : tail_head);
			end
			S_SUSP: if (resume_r) begin
				state_nxt = ret_r;
				cnt_nxt = ret_cnt_r;
			end
			S_FINAL: if (last) begin
				state_nxt = S_IDLE;
			end
		endcase
		take = boundary && int_pend_r;
		if (take) begin
			ret_nxt = state_nxt;
			state_nxt = S_SUSP;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_r <= S_IDLE;
			ret_r <= S_IDLE;
			cnt_r <= 16'h0000;
			ret_cnt_r <= 16'h0000;
			row_r <= 16'h0000;
			set_r <= 16'h0000;
			word_r <= 16'h0000;
			seg_set_r <= 1'b0;
			busy_r <= 1'b0;
			taken_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ret_r <= ret_nxt;
			cnt_r <= (take || (state_r == S_SUSP && !resume_r)) ? cnt_r
				: ((last || state_nxt != state_r) ? cnt_nxt : cnt_r - 16'h0001);
			ret_cnt_r <= take ? cnt_nxt : ret_cnt_r;
			row_r <= row_nxt;
			set_r <= set_nxt;
			word_r <= word_nxt;
			seg_set_r <= seg_nxt;
			busy_r <= state_nxt != S_IDLE;
			taken_r <= take;
		end
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			run_r <= '0;
		end else if (state_r == S_IDLE && start_r) begin
			run_r <= pack_cfg(ctrl_r, dims_r, geom_r);
		end
	end

	// State total: one per charged state, less the per-row adjustment
	assign counted = (state_r == S_SETUP || state_r == S_HEAD || state_r == S_FINAL
		|| (state_r == S_WORD && word_r != 16'h0000)) && cnt_r != 16'h0000;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			total_r <= 32'h0000_0000;
			setup_len_r <= 16'h0000;
		end else if (state_r == S_IDLE && start_r) begin
			total_r <= 32'h0000_0000;
			setup_len_r <= 16'h0000;
		end else begin
			if (state_r == S_ROWEND) begin
				total_r <= total_r - {16'h0000, adj};
			end else if (counted) begin
				total_r <= total_r + 32'h0000_0001;
			end
			if (state_r == S_SETUP) begin
				setup_len_r <= setup_len_r + 16'h0001;
			end
		end
	end

	// Flags: a set in the same cycle as a clear wins
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			done_r <= 1'b0;
			intr_r <= 1'b0;
		end else begin
			done_r <= (state_r == S_FINAL && last) || (done_r && !(state_r == S_IDLE && start_r));
			intr_r <= take || (intr_r && !(state_r == S_IDLE && start_r));
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);

	sequence s_linear_go;
		state_r == S_IDLE && start_r && !ctrl_r[pixel_expand_pkg::CTRL_XY];
	endsequence
	sequence s_final_entry;
		state_r != S_FINAL ##1 state_r == S_FINAL;
	endsequence

	property p_setup_linear;
		s_linear_go |=> (state_r == S_SETUP) [*4] ##1 state_r != S_SETUP;
	endproperty
	a_setup_linear: assert property (p_setup_linear) else $error("linear setup not 4 states");

	property p_setup_win;
		(state_r == S_SETUP && last && run_r.xy && run_r.win != 3'h3) |=>
			setup_len_r == (run_r.win == 3'h1 ? 16'h0009 : run_r.win == 3'h2 ? 16'h0011
			: run_r.win == 3'h4 ? 16'h0015 : 16'h0006);
	endproperty
	a_setup_win: assert property (p_setup_win) else $error("windowed setup length wrong");

	property p_setup_dim;
		(state_r == S_SETUP && last && run_r.xy && run_r.win == 3'h3) |=> setup_len_r == 16'h000C;
	endproperty
	a_setup_dim: assert property (p_setup_dim) else $error("end adjust setup not 12");

	property p_word_plain;
		(state_r == S_HEAD && last && !run_r.mask) |=> state_r == S_SUSP ||
			cnt_r == (run_r.op == 2'h0 ? 16'h0002 : run_r.op == 2'h1 ? 16'h0004
			: run_r.op == 2'h2 ? 16'h0005 : 16'h0006);
	endproperty
	a_word_plain: assert property (p_word_plain) else $error("plain word cost wrong");

	property p_word_rmw;
		(state_r == S_HEAD && last && run_r.mask) |=> state_r == S_SUSP ||
			cnt_r == (run_r.op == 2'h0 ? 16'h0004 : run_r.op == 2'h1 ? 16'h0006
			: run_r.op == 2'h2 ? 16'h0007 : 16'h0008);
	endproperty
	a_word_rmw: assert property (p_word_rmw) else $error("masked word cost wrong");

	property p_short_head;
		(state_r == S_SETUP && last && run_r.dy != 16'h0000
			&& rcase == pixel_expand_pkg::CASE_SHORT) |=>
			cnt_r == 16'h0003 + {13'h0000, run_r.r, 1'b0};
	endproperty
	a_short_head: assert property (p_short_head) else $error("short row head wrong");

	property p_set_count;
		(state_r == S_SETUP && last && run_r.dx > 16'h0020) |=>
			set_r == ((run_r.dx[5] || run_r.dx[15:5] == 11'h000) ? {5'h00, run_r.dx[15:5]}
			: {5'h00, run_r.dx[15:5]} - 16'h0001);
	endproperty
	a_set_count: assert property (p_set_count) else $error("set count wrong");

	property p_adjust;
		state_r == S_ROWEND |=> total_r == $past(total_r) - (!run_r.mask ? 32'h0 :
			run_r.align == 2'h3 ? 32'h4 : run_r.align == 2'h0 ? 32'h0 : 32'h2);
	endproperty
	a_adjust: assert property (p_adjust) else $error("row adjustment wrong");

	property p_int_latency;
		(int_pend_r && (state_r == S_HEAD || state_r == S_WORD)) |->
			##[0:20] (taken_r || state_r == S_SUSP || state_r == S_FINAL);
	endproperty
	a_int_latency: assert property (p_int_latency) else $error("interrupt not taken in time");

	property p_final;
		s_final_entry |-> (state_r == S_FINAL) [*3] ##1 (state_r == S_IDLE && done_r);
	endproperty
	a_final: assert property (p_final) else $error("closing states wrong");

	property p_count;
		counted && state_r != S_ROWEND |=> total_r == $past(total_r) + 32'h0000_0001;
	endproperty
	a_count: assert property (p_count) else $error("state not counted");
endmodule // pixel_block_expand_timing
`default_nettype wire

/* test/irq_source_model.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic fire,
	input wire logic taken,
	output logic req
);
	// Request held until the sequencer takes it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			req <= 1'b0;
		end else if (taken) begin
			req <= 1'b0;
		end else if (fire) begin
			req <= 1'b1;
		end
	end
endmodule // irq_source_model
`default_nettype wire

/* test/tb_pixel_block_expand_timing.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_pixel_block_expand_timing;
	logic clk, arst_n, rd, wr, fire, int_req, int_taken, busy, intr, wreq;
	logic [4:0] addr;
	logic [31:0] wdata, rdata, q;
	int n_fail, n_checks, k, m, i;
	int su[5] = '{6, 9, 17, 12, 21};
	int gt[4] = '{2, 4, 5, 6};
	pixel_block_expand_timing dut (.CLK(clk), .ARST_N(arst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wreq), .INT_REQ(int_req), .INT_TAKEN(int_taken), .BUSY(busy),
		.INTERRUPTED(intr));
	irq_source_model partner (.clk(clk), .arst_n(arst_n), .fire(fire), .taken(int_taken),
		.req(int_req));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task stop_test;
		$display("checks=%0d fails=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task acc(input logic w, input logic [4:0] a, input logic [31:0] d);
		int j;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		for (j = 0; j < 50; j++) begin
			@(posedge clk);
			if (wreq === 1'b0) break;
		end
		q = rdata;
		if (j == 50) begin
			n_fail++;
			stop_test();
		end
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task wt(input logic v, input int lim);
		int j;
		for (j = 0; j < lim; j++) begin
			@(posedge clk);
			if (busy === v) break;
		end
		if (j == lim) begin
			n_fail++;
			stop_test();
		end
	endtask
	function logic [31:0] cw(input int xy, input int win, input int op, input int mask);
		return {21'h0, mask[0], op[1:0], 2'h3, win[2:0], xy[0], 2'h1};
	endfunction
	function logic [31:0] gw(input int n, input int y, input int r, input int v, input int al,
		input int p);
		return {3'h0, p[4:0], 2'h0, al[1:0], v[1:0], r[1:0], y[7:0], n[7:0]};
	endfunction
	task load(input logic [31:0] c, input logic [31:0] dm, input logic [31:0] g);
		acc(1'b1, pixel_expand_pkg::OFS_DIMS, dm);
		acc(1'b1, pixel_expand_pkg::OFS_GEOM, g);
		acc(1'b1, pixel_expand_pkg::OFS_CTRL, c);
		wt(1'b1, 5);
	endtask
	task fin(input int tot);
		wt(1'b0, 5000);
		acc(1'b0, pixel_expand_pkg::OFS_TOTAL, 32'h0);
		`CHK(q, 32'(tot))
	endtask
	task run(input logic [31:0] c, input logic [31:0] dm, input logic [31:0] g, input int tot,
		input int stp);
		load(c, dm, g);
		fin(tot);
		acc(1'b0, pixel_expand_pkg::OFS_STAT, 32'h0);
		`CHK(q[1:0], 2'h2)
		acc(1'b0, pixel_expand_pkg::OFS_SETUP, 32'h0);
		`CHK(q, 32'(stp))
	endtask
	initial begin
		arst_n = 1'b0;
		{rd, wr, fire} = 3'h0;
		addr = 5'h00;
		wdata = 32'h0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		`CHK(wreq, 1'b1)
		acc(1'b0, pixel_expand_pkg::OFS_CTRL, 32'h0);
		`CHK(q, pixel_expand_pkg::CTRL_RST)
		acc(1'b0, pixel_expand_pkg::OFS_GEOM, 32'h0);
		`CHK(q, pixel_expand_pkg::GEOM_RST)
		acc(1'b0, pixel_expand_pkg::OFS_STAT, 32'h0);
		`CHK(q, 32'h0)
		acc(1'b0, 5'h18, 32'h0);
		`CHK(q, 32'h0)
		run(cw(0, 0, 0, 0), 32'h0001_0008, gw(1, 0, 1, 0, 0, 1), 4 + 7 + 3, 4);
		acc(1'b0, pixel_expand_pkg::OFS_CTRL, 32'h0);
		`CHK(q, 32'h0000_00C0)
		for (k = 0; k < 5; k++) begin
			run(cw(1, k, 0, 0), 32'h0001_0008, gw(1, 0, 1, 0, 0, 1), su[k] + 10, su[k]);
		end
		for (m = 0; m < 2; m++) begin
			for (k = 0; k < 4; k++) begin
				run(cw(1, 0, k, m), 32'h000A_000A, gw(6, 0, 2, 0, 3, 8),
					6 + (9 + 6 * (gt[k] + 2 * m)) * 10 + 3 - 40 * m, 6);
			end
		end
		run(cw(0, 0, 0, 1), 32'h0003_0014, gw(2, 0, 2, 0, 0, 4), 4 + 15 * 3 + 3, 4);
		run(cw(0, 0, 0, 1), 32'h0003_0014, gw(2, 0, 2, 0, 1, 4), 4 + 17 * 3 + 3 - 6, 4);
		run(cw(0, 0, 0, 1), 32'h0003_0014, gw(2, 0, 2, 0, 2, 4), 4 + 15 * 3 + 3 - 6, 4);
		run(cw(0, 0, 0, 0), 32'h0002_0040, gw(4, 2, 2, 1, 0, 1), 4 + 21 * 2 + 3, 4);
		run(cw(0, 0, 0, 0), 32'h0001_0060, gw(6, 3, 3, 2, 3, 2), 4 + 84 + 3, 4);
		run(cw(0, 0, 0, 0), 32'h0000_0008, gw(1, 0, 1, 0, 0, 1), 4 + 3, 4);
		load(cw(0, 0, 0, 0), 32'h0004_0008, gw(1, 0, 1, 0, 0, 1));
		acc(1'b1, pixel_expand_pkg::OFS_CTRL, cw(1, 4, 3, 1));
		acc(1'b1, pixel_expand_pkg::OFS_DIMS, 32'h0009_0009);
		fin(4 + 7 * 4 + 3);
		acc(1'b0, pixel_expand_pkg::OFS_DIMS, 32'h0);
		`CHK(q, 32'h0009_0009)
		load(cw(0, 0, 0, 0), 32'h0008_0040, gw(4, 2, 2, 1, 0, 1));
		repeat (20) @(posedge clk);
		fire <= 1'b1;
		@(posedge clk);
		fire <= 1'b0;
		for (i = 0; i < 26; i++) begin
			@(posedge clk);
			if (int_taken === 1'b1) break;
		end
		`CHK(i < 26, 1'b1)
		@(posedge clk);
		`CHK(intr, 1'b1)
		acc(1'b0, pixel_expand_pkg::OFS_STAT, 32'h0);
		`CHK(q[3:2], 2'h3)
		acc(1'b1, pixel_expand_pkg::OFS_CTRL, 32'h0000_0002);
		fin(4 + 21 * 8 + 3);
		stop_test();
	end
endmodule // tb_pixel_block_expand_timing
`default_nettype wire
